// File: verilog/sep_core.v
// Serial EEPROM device: instruction decoder, programming timer and array
`timescale 1ns/1ps
`include "sep_defines.vh"
// ----------------------------------------------------------------------------
// How it works
// - Select rise, start bit one, opcode, address
// - Write uses opcode 01, address, data
// - Erase-all is opcode 00 with 10 prefix
// - Write-all is opcode 00, 01 prefix, data
// - Data is 8 or 16 bits by organisation
// - Programming starts at last data bit, or at last address bit for erase and erase-all
// - Select raised after low shows ready/busy
// - Busy drives data-out low
// - Done drives data-out high
// - Select raised after completion shows nothing
// - Erase-all sets every array bit to one
// - Write-all stores data in every location
// - Program-disable blocks all erase and write
// - Reads work whether enabled or disabled
// - Byte mode ignores top address bit, clocked
// - Word mode ignores top address bit, clocked
// ----------------------------------------------------------------------------

module sep_core #(
    parameter [23:0] PROG_CYCLES = `SEP_PROG_CYCLES
) (
    input  wire ref_clk,
    input  wire sys_rst,
    input  wire chipSelect,
    input  wire shiftClock,
    input  wire serialIn,
    input  wire wordWidthSelect,
    output reg  serialOut,
    output reg  serialOutEn
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_OPC  = 3'h1;
    localparam [2:0] S_ADDR = 3'h2;
    localparam [2:0] S_DATA = 3'h3;
    localparam [2:0] S_READ = 3'h4;
    localparam [2:0] S_HOLD = 3'h5;

    wire [3:0] syncLevel;
    wire       csS  = syncLevel[0];
    wire       skS  = syncLevel[1];
    wire       diS  = syncLevel[2];
    wire       orgS = syncLevel[3];

    reg  [2:0]  state_r;
    reg         csPrev_r;
    reg         skPrev_r;
    reg  [4:0]  bitCnt_r;
    reg  [1:0]  op_r;
    reg  [8:0]  addr_r;
    reg  [15:0] data_r;
    reg         progEn_r;
    reg  [23:0] progCnt_r;
    reg         commit_r;
    reg  [1:0]  pendOp_r;
    reg  [7:0]  pendAddr_r;
    reg  [15:0] pendData_r;
    reg         statusShow_r;
    reg  [7:0]  rdAddr_r;
    reg  [4:0]  rdCnt_r;
    reg  [15:0] rdSh_r;

    wire        csRise    = csS & ~csPrev_r;
    wire        skRise    = skS & ~skPrev_r;
    wire        progBusy  = (progCnt_r != 24'h0);
    wire [8:0]  addrNxt   = {addr_r[7:0], diS};
    wire [15:0] dataNxt   = {data_r[14:0], diS};
    wire [1:0]  extCode   = orgS ? addrNxt[7:6] : addrNxt[8:7];
    // Top address bit is shifted in but dropped here
    wire [7:0]  cellAddr  = orgS ? {1'b0, addrNxt[6:0]} : addrNxt[7:0];
    wire [4:0]  addrLast  = orgS ? `SEP_ADDR_LAST_X16 : `SEP_ADDR_LAST_X8;
    wire [4:0]  dataLast  = orgS ? `SEP_DATA_LAST_X16 : `SEP_DATA_LAST_X8;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    sep_sync #(
        .WIDTH (4)
    ) uSync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn ({wordWidthSelect, serialIn, shiftClock, chipSelect}),
        .syncOut (syncLevel)
    );

    // ------------------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------------------
    // Flops without reset: contents stand for nonvolatile cells
    wire [8*`SEP_MEM_BYTES-1:0] memFlat;
    wire pendAll   = (pendOp_r == `SEP_PK_WRITE_ALL) || (pendOp_r == `SEP_PK_ERASE_ALL);
    wire pendErase = (pendOp_r == `SEP_PK_ERASE) || (pendOp_r == `SEP_PK_ERASE_ALL);

    genvar i;
    generate
        for (i = 0; i < `SEP_MEM_BYTES; i = i + 1) begin : gCell
            localparam [7:0] IDX = i;
            reg  [7:0] cell_r;
            wire       hit = pendAll
                             | (orgS ? (IDX[7:1] == pendAddr_r[6:0]) : (IDX == pendAddr_r));
            wire [7:0] wrByte = pendErase ? `SEP_ERASED_BYTE :
                                (orgS ? (IDX[0] ? pendData_r[7:0] : pendData_r[15:8])
                                      : pendData_r[7:0]);
            always @(posedge ref_clk) begin
                if (commit_r && hit) begin
                    cell_r <= wrByte;
                end
            end
            assign memFlat[8*i +: 8] = cell_r;
        end
    endgenerate

    // Read word left aligned so the first bit out is always bit 15
    wire [7:0]  evenByte = memFlat[8*{rdAddr_r[6:0], 1'b0} +: 8];
    wire [7:0]  oddByte  = memFlat[8*{rdAddr_r[6:0], 1'b1} +: 8];
    wire [7:0]  byteRd   = memFlat[8*rdAddr_r +: 8];
    wire [15:0] readWord = orgS ? {evenByte, oddByte} : {byteRd, 8'h00};

    // ------------------------------------------------------------------------
    // Instruction sequencer
    // ------------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r      <= S_IDLE;
            csPrev_r     <= 1'b0;
            skPrev_r     <= 1'b0;
            bitCnt_r     <= 5'h00;
            op_r         <= 2'h0;
            addr_r       <= 9'h000;
            data_r       <= 16'h0000;
            progEn_r     <= 1'b0;
            progCnt_r    <= 24'h000000;
            commit_r     <= 1'b0;
            pendOp_r     <= `SEP_PK_WRITE;
            pendAddr_r   <= 8'h00;
            pendData_r   <= 16'h0000;
            statusShow_r <= 1'b0;
            rdAddr_r     <= 8'h00;
            rdCnt_r      <= 5'h00;
            rdSh_r       <= 16'h0000;
            serialOut    <= 1'b0;
            serialOutEn  <= 1'b0;
        end else begin
            csPrev_r <= csS;
            skPrev_r <= skS;
            commit_r <= 1'b0;
            // Array is updated in the last cycle so ready means data is in
            if (progBusy) begin
                progCnt_r <= progCnt_r - 24'h000001;
                if (progCnt_r == 24'h000001) begin
                    commit_r <= 1'b1;
                end
            end
            if (statusShow_r && csS) begin
                serialOutEn <= 1'b1;
                serialOut   <= ~progBusy;
            end
            if (!csS) begin
                state_r      <= S_IDLE;
                statusShow_r <= 1'b0;
                serialOutEn  <= 1'b0;
                serialOut    <= 1'b0;
            end else if (csRise) begin
                state_r      <= S_IDLE;
                // Status only while the timer is still running
                statusShow_r <= progBusy;
            end else if (skRise) begin
                case (state_r)
                    S_IDLE: begin
                        // No new instruction is taken while programming
                        if (diS && !progBusy) begin
                            state_r      <= S_OPC;
                            bitCnt_r     <= 5'h00;
                            statusShow_r <= 1'b0;
                            serialOutEn  <= 1'b0;
                        end
                    end
                    S_OPC: begin
                        op_r     <= {op_r[0], diS};
                        bitCnt_r <= bitCnt_r + 5'h01;
                        if (bitCnt_r == `SEP_OPC_LAST) begin
                            state_r  <= S_ADDR;
                            bitCnt_r <= 5'h00;
                            addr_r   <= 9'h000;
                        end
                    end
                    S_ADDR: begin
                        addr_r   <= addrNxt;
                        bitCnt_r <= bitCnt_r + 5'h01;
                        if (bitCnt_r == addrLast) begin
                            bitCnt_r   <= 5'h00;
                            pendAddr_r <= cellAddr;
                            data_r     <= 16'h0000;
                            state_r    <= S_HOLD;
                            case (op_r)
                                `SEP_OP_READ: begin
                                    state_r     <= S_READ;
                                    rdAddr_r    <= cellAddr;
                                    rdCnt_r     <= 5'h00;
                                    serialOutEn <= 1'b1;
                                    serialOut   <= 1'b0;
                                end
                                `SEP_OP_WRITE: begin
                                    state_r  <= S_DATA;
                                    pendOp_r <= `SEP_PK_WRITE;
                                end
                                `SEP_OP_ERASE: begin
                                    if (progEn_r) begin
                                        pendOp_r  <= `SEP_PK_ERASE;
                                        progCnt_r <= PROG_CYCLES;
                                    end
                                end
                                default: begin
                                    case (extCode)
                                        `SEP_EXT_ENABLE: begin
                                            progEn_r <= 1'b1;
                                        end
                                        `SEP_EXT_DISABLE: begin
                                            progEn_r <= 1'b0;
                                        end
                                        `SEP_EXT_ERASE_ALL: begin
                                            if (progEn_r) begin
                                                pendOp_r  <= `SEP_PK_ERASE_ALL;
                                                progCnt_r <= PROG_CYCLES;
                                            end
                                        end
                                        default: begin
                                            state_r  <= S_DATA;
                                            pendOp_r <= `SEP_PK_WRITE_ALL;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                    S_DATA: begin
                        data_r   <= dataNxt;
                        bitCnt_r <= bitCnt_r + 5'h01;
                        if (bitCnt_r == dataLast) begin
                            state_r    <= S_HOLD;
                            pendData_r <= dataNxt;
                            if (progEn_r) begin
                                progCnt_r <= PROG_CYCLES;
                            end
                        end
                    end
                    S_READ: begin
                        if (rdCnt_r == 5'h00) begin
                            serialOut <= readWord[15];
                            rdSh_r    <= {readWord[14:0], 1'b0};
                            rdCnt_r   <= 5'h01;
                        end else begin
                            serialOut <= rdSh_r[15];
                            rdSh_r    <= {rdSh_r[14:0], 1'b0};
                            rdCnt_r   <= rdCnt_r + 5'h01;
                            // Sequential read: next word follows with no dummy bit
                            if (rdCnt_r == dataLast) begin
                                rdCnt_r  <= 5'h00;
                                rdAddr_r <= orgS ? {1'b0, rdAddr_r[6:0] + 7'h01}
                                                 : rdAddr_r + 8'h01;
                            end
                        end
                    end
                    S_HOLD: begin
                        state_r <= S_HOLD;
                    end
                    default: begin
                        state_r <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // sep_core

// File: verilog/sep_defines.vh
// Constants for the serial EEPROM programming block
`ifndef SEP_DEFINES_VH
`define SEP_DEFINES_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SEP_CLK_MHZ        100
`define SEP_TWP_MS         10
// Maximum programming time at the system clock, sized to the 24-bit timer
`define SEP_PROG_CYCLES    24'h0F4240

// ----------------------------------------------------------------------------
// Frame field lengths, minus one, as bit counter end values
// ----------------------------------------------------------------------------
`define SEP_OPC_LAST       5'h01
`define SEP_ADDR_LAST_X8   5'h08
`define SEP_ADDR_LAST_X16  5'h07
`define SEP_DATA_LAST_X8   5'h07
`define SEP_DATA_LAST_X16  5'h0F

// ----------------------------------------------------------------------------
// Operation codes and extended codes (leading two address bits)
// ----------------------------------------------------------------------------
`define SEP_OP_EXT         2'h0
`define SEP_OP_WRITE       2'h1
`define SEP_OP_READ        2'h2
`define SEP_OP_ERASE       2'h3
`define SEP_EXT_DISABLE    2'h0
`define SEP_EXT_WRITE_ALL  2'h1
`define SEP_EXT_ERASE_ALL  2'h2
`define SEP_EXT_ENABLE     2'h3

// ----------------------------------------------------------------------------
// Pending programming operations
// ----------------------------------------------------------------------------
`define SEP_PK_WRITE       2'h0
`define SEP_PK_ERASE       2'h1
`define SEP_PK_WRITE_ALL   2'h2
`define SEP_PK_ERASE_ALL   2'h3

`define SEP_MEM_BYTES      256
`define SEP_ERASED_BYTE    8'hFF

`endif

// File: verilog/sep_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module sep_sync #(
    parameter WIDTH = 4
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stage1_r;
    reg [WIDTH-1:0] stage2_r;
    reg [WIDTH-1:0] stage3_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            always @(posedge ref_clk) begin
                if (sys_rst) begin
                    stage1_r[i] <= 1'b0;
                    stage2_r[i] <= 1'b0;
                    stage3_r[i] <= 1'b0;
                    syncOut[i]  <= 1'b0;
                end else begin
                    stage1_r[i] <= asyncIn[i];
                    stage2_r[i] <= stage1_r[i];
                    stage3_r[i] <= stage2_r[i];
                    // A change counts only once two settled stages agree
                    if (stage2_r[i] == stage3_r[i]) begin
                        syncOut[i] <= stage2_r[i];
                    end
                end
            end
        end
    endgenerate

endmodule // sep_sync

// File: tb/sep_core_chk.sv
// Concurrent checks on the pins of the serial EEPROM programming block
`timescale 1ns/1ps
module sep_core_chk #(
    parameter [23:0] PROG_CYCLES = 24'h000064
) (
    input logic ref_clk,
    input logic sys_rst,
    input logic chipSelect,
    input logic shiftClock,
    input logic serialIn,
    input logic wordWidthSelect,
    input logic serialOut,
    input logic serialOutEn
);
    // ------------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------------
    // Age of the last raw shift-clock rise tells status bits apart from read bits
    logic [4:0]  skAge_r;
    logic        skPrev_r;
    logic [23:0] busyCnt_r;
    always_ff @(posedge ref_clk) begin
        skPrev_r <= shiftClock;
        if (sys_rst || (shiftClock && !skPrev_r))
            skAge_r <= 5'h00;
        else if (skAge_r != 5'h1F)
            skAge_r <= skAge_r + 5'h01;
        if (sys_rst || !(serialOutEn && !serialOut && skAge_r == 5'h1F))
            busyCnt_r <= 24'h000000;
        else
            busyCnt_r <= busyCnt_r + 24'h000001;
    end
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=> !serialOutEn && !serialOut)
        else $error("data-out active after reset");
    AST_IDLE_SILENT: assert property (!chipSelect [*8] |-> !serialOutEn)
        else $error("data-out driven without select");
    AST_EN_CAUSE: assert property ($rose(serialOutEn) |-> chipSelect && $past(chipSelect, 4))
        else $error("data-out driven too soon after select");
    AST_FIRST_ZERO: assert property ($rose(serialOutEn) |-> !serialOut)
        else $error("data-out did not start low");
    AST_READY_STANDS: assert property (serialOutEn && $past(serialOutEn) && $fell(serialOut) |-> skAge_r < 5'h0C)
        else $error("data-out fell without a shift clock");
    AST_STATUS_LEVEL: assert property (serialOutEn && serialOut && skAge_r == 5'h1F |=> serialOut || !serialOutEn)
        else $error("ready level not held");
    AST_BUSY_BOUND: assert property (busyCnt_r < PROG_CYCLES)
        else $error("busy longer than the programming cycle");
    AST_EN_STICKY: assert property ($fell(serialOutEn) |-> !$past(chipSelect, 3))
        else $error("data-out released while selected");
    cover property ($rose(serialOut) && serialOutEn && skAge_r == 5'h1F);
    cover property ($rose(serialOutEn) && skAge_r == 5'h1F);
    cover property (serialOutEn && serialOut && skAge_r < 5'h08);
endmodule // sep_core_chk

bind sep_core sep_core_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .chipSelect(chipSelect), .shiftClock(shiftClock), .serialIn(serialIn),
    .wordWidthSelect(wordWidthSelect), .serialOut(serialOut), .serialOutEn(serialOutEn));

// File: tb/sep_host.sv
// Behavioural host controller driving the three-wire serial link
`timescale 1ns/1ps
module sep_host (
    output logic chipSelect,
    output logic shiftClock,
    output logic serialIn,
    input  logic serialOut,
    input  logic serialOutEn
);
    // No pull on data-out, so a released pin reads as z
    wire doPin = serialOutEn ? serialOut : 1'bz;
    initial begin
        chipSelect = 1'b0;
        shiftClock = 1'b0;
        serialIn   = 1'b0;
    end
    task automatic sel(input logic v);
        chipSelect = v;
        shiftClock = 1'b0;
        #100;
    endtask
    // Pin sampled just before each rise and once after the last bit
    task automatic shift(input logic [31:0] v, input int n, output logic [31:0] rd);
        rd = 32'h00000000;
        for (int i = n - 1; i >= 0; i--) begin
            serialIn   = v[i];
            shiftClock = 1'b0;
            #40;
            rd         = {rd[30:0], doPin};
            shiftClock = 1'b1;
            #40;
        end
        shiftClock = 1'b0;
        serialIn   = ~serialIn;
        #40;
        rd = {rd[30:0], doPin};
    endtask
endmodule // sep_host

// File: tb/sep_core_tb.sv
// Self-checking bench for the serial EEPROM programming block
`timescale 1ns/1ps
module sep_core_tb;
    localparam logic [23:0] PROG = 24'h000064;
    logic        ref_clk;
    logic        sys_rst;
    logic        wordWidthSelect;
    wire         chipSelect, shiftClock, serialIn, serialOut, serialOutEn;
    int          n_errors;
    int          compares;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [8:0]  a;
    logic [15:0] d;

    sep_core #(.PROG_CYCLES(PROG)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .chipSelect(chipSelect),
        .shiftClock(shiftClock), .serialIn(serialIn), .wordWidthSelect(wordWidthSelect),
        .serialOut(serialOut), .serialOutEn(serialOutEn));
    sep_host host (.chipSelect(chipSelect), .shiftClock(shiftClock), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int alen(); return wordWidthSelect ? 8 : 9; endfunction
    function automatic int dlen(); return wordWidthSelect ? 16 : 8; endfunction
    // Extended code in the two leading address bits, the rest random
    function automatic logic [8:0] ext(input logic [1:0] e);
        return 9'((32'(e) << (alen() - 2)) | (xs() & ((32'h00000001 << (alen() - 2)) - 1)));
    endfunction
    task automatic check_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t pin got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t data got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [1:0] op, input logic [8:0] ad, input logic [15:0] dt, input bit dat);
        logic [31:0] v;
        int          n;
        v = {29'h00000000, 1'b1, op};
        v = (v << alen()) | (ad & ((32'h00000001 << alen()) - 1));
        n = 3 + alen();
        if (dat) begin
            v = (v << dlen()) | (dt & ((32'h00000001 << dlen()) - 1));
            n = n + dlen();
        end
        host.sel(1'b1);
        host.shift(v, n, rd);
        host.sel(1'b0);
        #300;
    endtask
    task automatic prog(input logic [1:0] op, input logic [8:0] ad, input logic [15:0] dt, input bit dat,
                        input bit busy, input int late);
        frame(op, ad, dt, dat);
        #(late);
        host.sel(1'b1);
        #50;
        if (busy) begin
            check_pin(host.doPin, 1'b0);
            // Poll in whole periods so pin changes stay off the sampling edge
            for (int i = 0; i < 200 && host.doPin !== 1'b1; i++) #10;
            check_pin(host.doPin, 1'b1);
        end else begin
            check_pin(serialOutEn, 1'b0);
        end
        host.sel(1'b0);
    endtask
    task automatic read_chk(input logic [8:0] ad, input logic [15:0] exp);
        logic [31:0] m;
        frame(2'h2, ad, 16'h0000, 1'b1);
        m = (32'h00000001 << (dlen() + 1)) - 1;
        // Dummy zero sits just above the data bits
        check_data(rd & m, 32'(exp) & (m >> 1));
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    initial begin
        #500000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        seed            = 32'h000090D6;
        n_errors        = 0;
        compares        = 0;
        sys_rst         = 1'b1;
        wordWidthSelect = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        #100;
        check_pin(serialOutEn, 1'b0);
        prog(2'h1, 9'(xs()), 16'(xs()), 1'b1, 1'b0, 0);
        frame(2'h0, ext(2'h3), 16'h0000, 1'b0);
        d = 16'(xs());
        prog(2'h0, ext(2'h1), d, 1'b1, 1'b1, 0);
        repeat (3) read_chk(9'(xs()), d);
        prog(2'h0, ext(2'h2), 16'h0000, 1'b0, 1'b1, 0);
        repeat (2) read_chk(9'(xs()), 16'hFFFF);
        repeat (4) begin
            a = 9'(xs());
            d = 16'(xs());
            prog(2'h1, a, d, 1'b1, 1'b1, 0);
            read_chk(a ^ 9'h100, d);
        end
        d = ~d;
        prog(2'h1, a, d, 1'b1, 1'b0, 1500);
        read_chk(a, d);
        @(posedge ref_clk);
        #1 wordWidthSelect = 1'b1;
        repeat (2) begin
            a = 9'(xs());
            d = 16'(xs());
            prog(2'h1, a, d, 1'b1, 1'b1, 0);
            read_chk(a ^ 9'h080, d);
        end
        frame(2'h0, ext(2'h0), 16'h0000, 1'b0);
        prog(2'h1, a, ~d, 1'b1, 1'b0, 0);
        prog(2'h0, ext(2'h2), 16'h0000, 1'b0, 1'b0, 0);
        prog(2'h0, ext(2'h1), ~d, 1'b1, 1'b0, 0);
        read_chk(a, d);
        finish_test();
    end
endmodule // sep_core_tb
